// File: sdmc_regs.svh
// Purpose: Register offsets, field positions, reset values and timing counts
//          for the stereo DAC mode control block.
// Assumes: Eight-bit registers on the serial control port.
// Notes:   Definitions only; included by its bare name.
`ifndef SDMC_REGS_SVH
`define SDMC_REGS_SVH

// Register offsets on the serial control port.
`define SDMC_ADDR_RATE 8'h10
`define SDMC_ADDR_PSAVE_FMT 8'h11
`define SDMC_ADDR_OP_FILTER 8'h12
`define SDMC_ADDR_PHASE 8'h13
`define SDMC_ADDR_MUTE 8'h14
`define SDMC_ADDR_SILENCE 8'h15
`define SDMC_ADDR_ATT_FLAG 8'h16

// Field positions inside the registers.
`define SDMC_RATE_LSB 0
`define SDMC_PSAVE_BIT 7
`define SDMC_FMT_LSB 0
`define SDMC_OPDIS_BIT 4
`define SDMC_ROLLOFF_BIT 0
`define SDMC_PHASE_LSB 0
`define SDMC_MUTE_LSB 0
`define SDMC_SILENCE_LSB 0
`define SDMC_RANGE_BIT 7
`define SDMC_EMPH_LSB 4
`define SDMC_FNSEL_BIT 3
`define SDMC_COMB_BIT 1
`define SDMC_POL_BIT 0

// Reset values.
`define SDMC_RST_BIT 1'b0
`define SDMC_RST_PAIR 2'b00
`define SDMC_RST_FMT 3'b000
`define SDMC_RST_ATT_CODE 8'hFF

// Attenuator codes at and below which the channel is muted.
`define SDMC_FLOOR_FINE 8'h80
`define SDMC_FLOOR_WIDE 8'h9A

// Sample periods per attenuator step.
`define SDMC_STEP_SAMPLES 8

// System clocks per sample period that bound the rate classes.
`define SDMC_QUAD_BELOW 12'h0E0
`define SDMC_DUAL_BELOW 12'h1C0

`endif

// File: sdmc_pkg.sv
// Purpose: Types shared by the stereo DAC mode control block.
// Assumes: Nothing beyond SystemVerilog.
// Notes:   Constants live in sdmc_regs.svh.
`default_nettype none
package sdmc_pkg;

  // Rate class, encoded as the rate mode field forces it.
  typedef enum logic [1:0] {
    RC_AUTO = 2'b00,
    RC_SINGLE = 2'b01,
    RC_DUAL = 2'b10,
    RC_QUAD = 2'b11
  } sdmc_rate_t;

  // Analog output drive state, one-hot.
  typedef enum logic [2:0] {
    OM_NORMAL = 3'b001,
    OM_COMMON = 3'b010,
    OM_GROUND = 3'b100
  } sdmc_out_mode_t;

  // Settings consumed by the datapath.
  typedef struct packed {
    logic [2:0] serial_format_select;
    logic rolloff_select;
    logic [1:0] phase_invert;
    logic attenuation_range_select;
    logic [1:0] emphasis_rate_select;
  } sdmc_cfg_t;

endpackage
`default_nettype wire

// File: sdmc_ramp.sv
// Purpose: One channel of the digital attenuator with soft mute ramping.
// Assumes: sample_tick pulses once per sample period on the same clock.
// Notes:   Codes follow the attenuation level register; 8'hFF is 0 dB.
`timescale 1ns/10ps
`default_nettype none
`include "sdmc_regs.svh"
module sdmc_ramp
  import sdmc_pkg::*;
(
  input wire logic clk, // System clock.
  input wire logic rstn, // Synchronous reset, active low.
  input wire logic sample_tick, // One pulse per sample period.
  input wire logic range_wide, // One-decibel wide range when high.
  input wire logic mute_req, // Soft silence request for this channel.
  input wire logic [7:0] level, // Programmed attenuation code.
  output logic [7:0] code_q, // Present attenuator code.
  output logic muted_q // High while the channel is at infinite attenuation.
);

  logic [2:0] step_cnt_q;
  logic [7:0] floor_code;
  logic [7:0] target;
  logic step_now;

  // Mute wins over the programmed level; low codes sit at the floor.
  always_comb
  begin
    floor_code = range_wide ? `SDMC_FLOOR_WIDE : `SDMC_FLOOR_FINE;
    if (mute_req && code_q < floor_code) // RULE_12
      target = code_q;
    else if (mute_req) // RULE_12
      target = floor_code;
    else if (level < floor_code)
      target = floor_code;
    else
      target = level;
    step_now = sample_tick && (step_cnt_q == 3'(`SDMC_STEP_SAMPLES - 1));
  end

  // Counts sample periods between steps.
  always_ff @(posedge clk)
  begin
    if (!rstn)
      step_cnt_q <= 3'h0;
    else if (sample_tick)
      step_cnt_q <= step_cnt_q + 3'h1; // RULE_21
  end

  // Moves one code toward the target on each step, both ways alike.
  always_ff @(posedge clk)
  begin
    if (!rstn)
      code_q <= `SDMC_RST_ATT_CODE;
    else if (step_now && code_q > target)
      code_q <= code_q - 8'h01; // RULE_10
    else if (step_now && code_q < target)
      code_q <= code_q + 8'h01; // RULE_11
  end

  // Mute status follows the code reaching the floor.
  always_ff @(posedge clk)
  begin
    if (!rstn)
      muted_q <= 1'b0;
    else
      muted_q <= (code_q <= floor_code);
  end

  code_step_a: assert property (@(posedge clk) disable iff (!rstn) // RULE_21
    code_q != $past(code_q) |-> $past(sample_tick) && $past(step_cnt_q) == 3'h7)
    else $error("attenuator stepped off the eight-sample grid");

  mute_hold_a: assert property (@(posedge clk) disable iff (!rstn) // RULE_12
    mute_req && $past(mute_req) && $past(rstn) |-> code_q <= $past(code_q))
    else $error("attenuator rose while mute requested");

endmodule
`default_nettype wire

// File: sdmc_top.sv
// Purpose: Mode control of a stereo delta-sigma DAC: rate class, format,
//          operation disable, filter, phase, soft mute, de-emphasis and
//          silence flag pins.
// Assumes: clk is the system clock; sample_clk_in is the asynchronous
//          sample clock pin; silence detects come from same-clock logic.
// Notes:   Register reads return one cycle after the address is presented.
`timescale 1ns/10ps
`default_nettype none
`include "sdmc_regs.svh"
// Functional notes
// [RULE_01] Auto mode classifies clock ratio into rate
// [RULE_02] Rate field: auto, single, dual, quad
// [RULE_03] Power-save select picks disable flavour
// [RULE_04] Three-bit field selects serial audio format
// [RULE_05] Disable cuts input and resets data
// [RULE_06] Disable drives common mode or ground
// [RULE_07] Registers stay accessible while disabled
// [RULE_08] Roll-off bit: sharp or slow
// [RULE_09] Phase bits invert left and right
// [RULE_10] Soft mute ramps attenuator down
// [RULE_11] Unmute ramps back to programmed level
// [RULE_12] Mute overrides programmed attenuation
// [RULE_13] Read-only live per-channel silence status
// [RULE_14] Range bit: half-dB fine or one-dB wide
// [RULE_15] Two-bit field picks de-emphasis curve
// [RULE_16] Flag two pin: flag or analog mute
// [RULE_17] Combination: separate, or OR and AND
// [RULE_18] Reserved bits unused, written as zero
// [RULE_19] All fields reset to zero
// [RULE_20] Polarity: high or low on detection
// [RULE_21] One attenuator step per eight samples
// [RULE_22] Combine channels first, then apply polarity
module sdmc_top
  import sdmc_pkg::*;
(
  input wire logic clk, // System clock.
  input wire logic rstn, // Synchronous reset, active low.
  input wire logic reg_wr, // Write strobe from the serial control port.
  input wire logic [7:0] reg_addr, // Register offset.
  input wire logic [7:0] reg_wdata, // Write data.
  output logic [7:0] reg_rdata_q, // Read data for last cycle's address.
  input wire logic sample_clk_in, // Sample clock pin, asynchronous.
  input wire logic silence_left, // Left channel zero input detected.
  input wire logic silence_right, // Right channel zero input detected.
  input wire logic analog_silence_status, // Analog mute circuit state.
  input wire logic [7:0] att_level_left, // Programmed left attenuation code.
  input wire logic [7:0] att_level_right, // Programmed right attenuation code.
  output sdmc_cfg_t cfg_q, // Format, filter, phase, range, emphasis.
  output sdmc_rate_t rate_class_q, // Active rate class.
  output sdmc_out_mode_t out_mode_q, // Analog output drive state.
  output logic input_disconnect_q, // Serial audio input cut off.
  output logic data_reset_q, // Internal DAC data held in reset.
  output logic power_down_q, // DAC in power-down.
  output logic [7:0] att_code_left, // Left attenuator code.
  output logic [7:0] att_code_right, // Right attenuator code.
  output logic muted_left, // Left at infinite attenuation.
  output logic muted_right, // Right at infinite attenuation.
  output logic silence_flag_one_q, // First silence flag pin.
  output logic silence_flag_two_q // Second silence flag pin.
);

  // Maps a sample period in system clocks onto a rate class.
  function automatic sdmc_rate_t sdmc_rate_of(input logic [11:0] period);
    if (period < `SDMC_QUAD_BELOW)
      sdmc_rate_of = RC_QUAD;
    else if (period < `SDMC_DUAL_BELOW)
      sdmc_rate_of = RC_DUAL;
    else
      sdmc_rate_of = RC_SINGLE;
  endfunction

  logic [1:0] rate_class_select_q;
  logic powerdown_on_disable_select_q;
  logic operation_disable_q;
  logic [1:0] soft_silence_request_q;
  logic flag_pin_function_select_q;
  logic flag_combination_select_q;
  logic flag_polarity_select_q;
  logic smp_meta_q;
  logic smp_sync_q;
  logic smp_prev_q;
  logic sample_tick_q;
  logic [11:0] period_cnt_q;
  sdmc_rate_t detected_rate_q;
  logic flag_one_raw;
  logic flag_two_raw;
  logic [7:0] rd_value;

  // Register writes; reserved bits are dropped and the port works in
  // every operating state, including power-down.
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      rate_class_select_q <= `SDMC_RST_PAIR; // RULE_19
      powerdown_on_disable_select_q <= `SDMC_RST_BIT;
      operation_disable_q <= `SDMC_RST_BIT;
      soft_silence_request_q <= `SDMC_RST_PAIR;
      flag_pin_function_select_q <= `SDMC_RST_BIT;
      flag_combination_select_q <= `SDMC_RST_BIT;
      flag_polarity_select_q <= `SDMC_RST_BIT;
      cfg_q.serial_format_select <= `SDMC_RST_FMT;
      cfg_q.rolloff_select <= `SDMC_RST_BIT;
      cfg_q.phase_invert <= `SDMC_RST_PAIR;
      cfg_q.attenuation_range_select <= `SDMC_RST_BIT;
      cfg_q.emphasis_rate_select <= `SDMC_RST_PAIR;
    end
    else if (reg_wr) // RULE_07
    begin
      case (reg_addr)
        `SDMC_ADDR_RATE:
          rate_class_select_q <= reg_wdata[`SDMC_RATE_LSB +: 2]; // RULE_02
        `SDMC_ADDR_PSAVE_FMT:
        begin
          powerdown_on_disable_select_q <= reg_wdata[`SDMC_PSAVE_BIT];
          cfg_q.serial_format_select <= reg_wdata[`SDMC_FMT_LSB +: 3]; // RULE_04
        end
        `SDMC_ADDR_OP_FILTER:
        begin
          operation_disable_q <= reg_wdata[`SDMC_OPDIS_BIT];
          cfg_q.rolloff_select <= reg_wdata[`SDMC_ROLLOFF_BIT]; // RULE_08
        end
        `SDMC_ADDR_PHASE:
          cfg_q.phase_invert <= reg_wdata[`SDMC_PHASE_LSB +: 2]; // RULE_09
        `SDMC_ADDR_MUTE:
          soft_silence_request_q <= reg_wdata[`SDMC_MUTE_LSB +: 2];
        `SDMC_ADDR_ATT_FLAG:
        begin
          cfg_q.attenuation_range_select <= reg_wdata[`SDMC_RANGE_BIT]; // RULE_14
          cfg_q.emphasis_rate_select <= reg_wdata[`SDMC_EMPH_LSB +: 2]; // RULE_15
          flag_pin_function_select_q <= reg_wdata[`SDMC_FNSEL_BIT];
          flag_combination_select_q <= reg_wdata[`SDMC_COMB_BIT];
          flag_polarity_select_q <= reg_wdata[`SDMC_POL_BIT];
        end
        default:
        begin
        end
      endcase
    end
  end

  // Read multiplexer; reserved bits and unmapped offsets read as zero.
  always_comb
  begin
    rd_value = 8'h00; // RULE_18
    case (reg_addr)
      `SDMC_ADDR_RATE:
        rd_value[`SDMC_RATE_LSB +: 2] = rate_class_select_q;
      `SDMC_ADDR_PSAVE_FMT:
      begin
        rd_value[`SDMC_PSAVE_BIT] = powerdown_on_disable_select_q;
        rd_value[`SDMC_FMT_LSB +: 3] = cfg_q.serial_format_select;
      end
      `SDMC_ADDR_OP_FILTER:
      begin
        rd_value[`SDMC_OPDIS_BIT] = operation_disable_q;
        rd_value[`SDMC_ROLLOFF_BIT] = cfg_q.rolloff_select;
      end
      `SDMC_ADDR_PHASE:
        rd_value[`SDMC_PHASE_LSB +: 2] = cfg_q.phase_invert;
      `SDMC_ADDR_MUTE:
        rd_value[`SDMC_MUTE_LSB +: 2] = soft_silence_request_q;
      `SDMC_ADDR_SILENCE:
        rd_value[`SDMC_SILENCE_LSB +: 2] = {silence_right, silence_left}; // RULE_13
      `SDMC_ADDR_ATT_FLAG:
      begin
        rd_value[`SDMC_RANGE_BIT] = cfg_q.attenuation_range_select;
        rd_value[`SDMC_EMPH_LSB +: 2] = cfg_q.emphasis_rate_select;
        rd_value[`SDMC_FNSEL_BIT] = flag_pin_function_select_q;
        rd_value[`SDMC_COMB_BIT] = flag_combination_select_q;
        rd_value[`SDMC_POL_BIT] = flag_polarity_select_q;
      end
      default:
        rd_value = 8'h00;
    endcase
  end

  // Registered read data.
  always_ff @(posedge clk)
  begin
    if (!rstn)
      reg_rdata_q <= 8'h00;
    else
      reg_rdata_q <= rd_value;
  end

  // Two-stage synchroniser on the sample clock pin, then edge detect.
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      smp_meta_q <= 1'b0;
      smp_sync_q <= 1'b0;
      smp_prev_q <= 1'b0;
      sample_tick_q <= 1'b0;
    end
    else
    begin
      smp_meta_q <= sample_clk_in;
      smp_sync_q <= smp_meta_q;
      smp_prev_q <= smp_sync_q;
      sample_tick_q <= smp_sync_q && !smp_prev_q;
    end
  end

  // Measures system clocks per sample period; idles at zero until the first
  // edge so a partial period after reset is never classified, and saturates
  // if the sample clock stops.
  always_ff @(posedge clk)
  begin
    if (!rstn)
      period_cnt_q <= 12'h000;
    else if (sample_tick_q)
      period_cnt_q <= 12'h001;
    else if (period_cnt_q != 12'h000 && period_cnt_q != 12'hFFF)
      period_cnt_q <= period_cnt_q + 12'h001;
  end

  // Classifies each completed period.
  always_ff @(posedge clk)
  begin
    if (!rstn)
      detected_rate_q <= RC_SINGLE;
    else if (sample_tick_q && period_cnt_q != 12'h000)
      detected_rate_q <= sdmc_rate_of(period_cnt_q); // RULE_01
  end

  // Active rate class: forced by the field or taken from detection.
  always_ff @(posedge clk)
  begin
    if (!rstn)
      rate_class_q <= RC_SINGLE;
    else if (rate_class_select_q == RC_AUTO)
      rate_class_q <= detected_rate_q; // RULE_01
    else
      rate_class_q <= sdmc_rate_t'(rate_class_select_q); // RULE_02
  end

  // Operation disable: cut input, reset data, pick drive and power state.
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      out_mode_q <= OM_NORMAL;
      input_disconnect_q <= 1'b0;
      data_reset_q <= 1'b0;
      power_down_q <= 1'b0;
    end
    else
    begin
      input_disconnect_q <= operation_disable_q; // RULE_05
      data_reset_q <= operation_disable_q; // RULE_05
      power_down_q <= operation_disable_q && !powerdown_on_disable_select_q; // RULE_03
      case ({operation_disable_q, powerdown_on_disable_select_q})
        2'b10: out_mode_q <= OM_GROUND; // RULE_06
        2'b11: out_mode_q <= OM_COMMON; // RULE_06
        default: out_mode_q <= OM_NORMAL;
      endcase
    end
  end

  // Per-channel attenuators carrying the soft silence ramps.
  sdmc_ramp u_ramp_left (
    .clk(clk),
    .rstn(rstn),
    .sample_tick(sample_tick_q),
    .range_wide(cfg_q.attenuation_range_select),
    .mute_req(soft_silence_request_q[0]),
    .level(att_level_left),
    .code_q(att_code_left),
    .muted_q(muted_left)
  );

  sdmc_ramp u_ramp_right (
    .clk(clk),
    .rstn(rstn),
    .sample_tick(sample_tick_q),
    .range_wide(cfg_q.attenuation_range_select),
    .mute_req(soft_silence_request_q[1]),
    .level(att_level_right),
    .code_q(att_code_right),
    .muted_q(muted_right)
  );

  // Channel combination comes first, polarity after it.
  always_comb
  begin
    if (flag_combination_select_q) // RULE_17
    begin
      flag_one_raw = silence_left || silence_right;
      flag_two_raw = silence_left && silence_right;
    end
    else
    begin
      flag_one_raw = silence_left;
      flag_two_raw = silence_right;
    end
  end

  // Flag pins; the second may carry analog mute status instead.
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      silence_flag_one_q <= 1'b0;
      silence_flag_two_q <= 1'b0;
    end
    else
    begin
      silence_flag_one_q <= flag_one_raw ^ flag_polarity_select_q; // RULE_22
      if (flag_pin_function_select_q)
        silence_flag_two_q <= analog_silence_status; // RULE_16
      else
        silence_flag_two_q <= flag_two_raw ^ flag_polarity_select_q; // RULE_20
    end
  end

  // A completed sample period seen on the synchronised clock.
  sequence period_done_s;
    sample_tick_q && period_cnt_q != 12'h000;
  endsequence

  sequence auto_mode_s;
    (rate_class_select_q == RC_AUTO)[*2];
  endsequence

  auto_rate_a: assert property (@(posedge clk) disable iff (!rstn) // RULE_01
    auto_mode_s ##0 period_done_s ##0 (rate_class_select_q == RC_AUTO)[*2]
    |=> rate_class_q == sdmc_rate_of($past(period_cnt_q, 2)))
    else $error("auto rate class does not match measured period");

  forced_rate_a: assert property (@(posedge clk) disable iff (!rstn) // RULE_02
    rate_class_select_q != RC_AUTO |=> rate_class_q == $past(rate_class_select_q))
    else $error("forced rate class not applied");

  common_mode_a: assert property (@(posedge clk) disable iff (!rstn) // RULE_06
    operation_disable_q && powerdown_on_disable_select_q
    |=> out_mode_q == OM_COMMON && !power_down_q && data_reset_q)
    else $error("disable without power save drove wrong state");

  ground_down_a: assert property (@(posedge clk) disable iff (!rstn) // RULE_03
    operation_disable_q && !powerdown_on_disable_select_q
    |=> out_mode_q == OM_GROUND && power_down_q && input_disconnect_q)
    else $error("power-save disable drove wrong state");

  status_read_a: assert property (@(posedge clk) disable iff (!rstn) // RULE_13
    reg_addr == `SDMC_ADDR_SILENCE
    |=> reg_rdata_q == {6'h00, $past(silence_right), $past(silence_left)})
    else $error("silence status read mismatch");

  flag_one_a: assert property (@(posedge clk) disable iff (!rstn) // RULE_22
    1'b1 |=> silence_flag_one_q == ($past(flag_polarity_select_q) ^
      ($past(flag_combination_select_q) ?
      ($past(silence_left) || $past(silence_right)) : $past(silence_left))))
    else $error("flag one combination or polarity wrong");

  flag_two_a: assert property (@(posedge clk) disable iff (!rstn) // RULE_16
    flag_pin_function_select_q |=> silence_flag_two_q == $past(analog_silence_status))
    else $error("flag two pin not showing analog mute");

  reset_zero_a: assert property (@(posedge clk) // RULE_19
    !rstn |=> cfg_q == '0 && rate_class_select_q == 2'b00 && !operation_disable_q
      && soft_silence_request_q == 2'b00 && !flag_polarity_select_q)
    else $error("fields not zero after reset");

  disabled_write_a: assert property (@(posedge clk) disable iff (!rstn) // RULE_07
    operation_disable_q && reg_wr && reg_addr == `SDMC_ADDR_PHASE
    |=> cfg_q.phase_invert == $past(reg_wdata[1:0]))
    else $error("register write lost while disabled");

endmodule
`default_nettype wire

// File: sdmc_host_model.sv
// Purpose: Host controller model that writes and reads the mode registers.
// Assumes: Requests change one nanosecond after a rising clock edge.
// Notes:   Read data is taken one cycle after the address is presented.
`timescale 1ns/10ps
`default_nettype none
module sdmc_host_model
(
  input wire logic clk, // System clock.
  output logic reg_wr, // Write strobe.
  output logic [7:0] reg_addr, // Register offset.
  output logic [7:0] reg_wdata, // Write data.
  input wire logic [7:0] reg_rdata_q // Registered read data.
);
  // The port idles with no strobe and offset zero.
  initial
  begin
    reg_wr = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end

  // One-cycle write pulse; callers keep format codes legal but may set spare bits.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk);
    #1;
    reg_wr = 1'b0;
  endtask

  // The address is held until the registered answer has landed.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    #1;
    reg_addr = a;
    @(posedge clk);
    #1;
    d = reg_rdata_q;
  endtask
endmodule
`default_nettype wire

// File: test_stereo_dac_mode_control.sv
// Purpose: Self-checking bench for the stereo DAC mode control block.
// Assumes: 125 MHz clock; sample clock pin made here with a chosen ratio.
// Notes:   Inputs change one nanosecond after the rising edge.
`timescale 1ns/10ps
`default_nettype none
module test_stereo_dac_mode_control;
  import sdmc_pkg::*;
  logic clk, rstn, reg_wr, sclk, sil_l, sil_r, asil, l, r, c, p;
  logic [7:0] reg_addr, reg_wdata, rdq, rd, lvl_l, lvl_r, att_l, att_r, v;
  logic mut_l, mut_r, f1, f2, dis, drst, pd;
  sdmc_cfg_t cfg;
  sdmc_rate_t rate;
  sdmc_out_mode_t om;
  int n_fail, n_tests, sper, n;
  int hp[7] = '{64, 96, 128, 192, 256, 384, 576};
  logic [7:0] ex[7] = '{8'h03, 8'h03, 8'h02, 8'h02, 8'h01, 8'h01, 8'h01};

  sdmc_top u_sdmc_top (.clk(clk), .rstn(rstn), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata_q(rdq), .sample_clk_in(sclk), .silence_left(sil_l),
    .silence_right(sil_r), .analog_silence_status(asil), .att_level_left(lvl_l),
    .att_level_right(lvl_r), .cfg_q(cfg), .rate_class_q(rate), .out_mode_q(om),
    .input_disconnect_q(dis), .data_reset_q(drst), .power_down_q(pd),
    .att_code_left(att_l), .att_code_right(att_r), .muted_left(mut_l),
    .muted_right(mut_r), .silence_flag_one_q(f1), .silence_flag_two_q(f2));
  sdmc_host_model u_sdmc_host_model (.clk(clk), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata_q(rdq));

  // System clock, 8 ns period.
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Sample clock with half period sper system clocks; still while sper is zero.
  initial
  begin
    sclk = 1'b0;
    forever
    begin
      if (sper == 0)
        @(posedge clk);
      else
      begin
        repeat (sper) @(posedge clk);
        #1 sclk = ~sclk;
      end
    end
  end

  // Compares one value and counts it.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic disable_state(input logic [7:0] mode, input logic [7:0] pdn);
    tick(2);
    chk({5'h0, om}, mode, "drive state");
    chk({7'h0, pd}, pdn, "power down");
    chk({6'h0, dis, drst}, 8'h03, "input cut and data reset");
  endtask

  // Waits a bounded time for an attenuator code, then checks it.
  task automatic wait_att(input logic rs, input logic [7:0] t);
    n = 0;
    while ((rs ? att_r : att_l) !== t && n < 20000)
    begin
      tick(1);
      n++;
    end
    chk(rs ? att_r : att_l, t, "attenuator target");
  endtask

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Watchdog sized above the longest ramp sequence.
  initial
  begin
    repeat (95000) @(posedge clk);
    n_fail++;
    $display("BAD t=%0t watchdog expired", $time);
    end_sim;
  end

  // Main sequence.
  initial
  begin
    n_fail = 0;
    n_tests = 0;
    sper = 0;
    rstn = 1'b0;
    {sil_l, sil_r, asil} = 3'b000;
    lvl_l = 8'hFF;
    lvl_r = 8'hFF;
    repeat (6) @(posedge clk);
    #1 rstn = 1'b1;
    for (int a = 16; a < 23; a++)
    begin
      u_sdmc_host_model.rd(a[7:0], rd);
      chk(rd, 8'h00, "reset value");
    end
    chk({6'h0, rate}, 8'h01, "rate after reset");
    chk({5'h0, om}, 8'h01, "drive after reset");
    $display("reset test done");
    for (int f = 0; f < 6; f++)
    begin
      u_sdmc_host_model.wr(8'h11, f[7:0]);
      tick(2);
      chk({5'h0, cfg.serial_format_select}, f[7:0], "format");
    end
    u_sdmc_host_model.wr(8'h11, 8'hFD);
    u_sdmc_host_model.rd(8'h11, rd);
    chk(rd, 8'h85, "spare bits dropped");
    u_sdmc_host_model.wr(8'h12, 8'hEE);
    u_sdmc_host_model.wr(8'h15, 8'hFF);
    u_sdmc_host_model.wr(8'h17, 8'hFF);
    for (int a = 18; a < 24; a++)
    begin
      u_sdmc_host_model.rd(a[7:0], rd);
      chk(rd, 8'h00, "spare, status or unmapped write ignored");
    end
    u_sdmc_host_model.wr(8'h12, 8'h10);
    disable_state(8'h02, 8'h00);
    u_sdmc_host_model.wr(8'h11, 8'h05);
    disable_state(8'h04, 8'h01);
    u_sdmc_host_model.wr(8'h13, 8'h02);
    u_sdmc_host_model.rd(8'h13, rd);
    chk(rd, 8'h02, "access while powered down");
    u_sdmc_host_model.wr(8'h12, 8'h01);
    tick(2);
    chk({4'h0, om, cfg.rolloff_select}, 8'h03, "normal drive, slow roll-off");
    for (int k = 0; k < 4; k++)
    begin
      u_sdmc_host_model.wr(8'h13, k[7:0]);
      u_sdmc_host_model.wr(8'h16, {2'b00, k[1:0], 4'h0});
      tick(2);
      chk({6'h0, cfg.phase_invert}, k[7:0], "phase");
      chk({6'h0, cfg.emphasis_rate_select}, k[7:0], "emphasis");
    end
    $display("settings test done");
    for (int k = 1; k < 4; k++)
    begin
      u_sdmc_host_model.wr(8'h10, k[7:0]);
      tick(2);
      chk({6'h0, rate}, k[7:0], "forced rate");
    end
    u_sdmc_host_model.wr(8'h10, 8'h00);
    for (int k = 0; k < 7; k++)
    begin
      sper = hp[k];
      tick(10 * hp[k]);
      chk({6'h0, rate}, ex[k], "detected rate");
    end
    $display("rate test done");
    for (int i = 0; i < 16; i++)
    begin
      {p, c, r, l} = i[3:0];
      u_sdmc_host_model.wr(8'h16, {6'h0, c, p});
      {sil_l, sil_r} = {l, r};
      tick(2);
      u_sdmc_host_model.rd(8'h15, rd);
      chk(rd, {6'h0, r, l}, "silence status");
      chk({6'h0, f2, f1}, {6'h0, (c ? l & r : r) ^ p, (c ? l | r : l) ^ p}, "flags");
    end
    u_sdmc_host_model.wr(8'h16, 8'h09);
    for (int k = 0; k < 2; k++)
    begin
      asil = k[0];
      tick(2);
      chk({7'h0, f2}, k[7:0], "flag two as analog status");
    end
    $display("flag test done");
    sper = 8;
    u_sdmc_host_model.wr(8'h16, 8'h00);
    lvl_l = 8'hF0;
    wait_att(1'b0, 8'hF0);
    u_sdmc_host_model.wr(8'h14, 8'h01);
    wait_att(1'b0, 8'hEF);
    v = att_l;
    n = 0;
    while (att_l === v && n < 2000)
    begin
      tick(1);
      n++;
    end
    chk(n[7:0], 8'h80, "clocks per step");
    chk(att_l, v - 8'h01, "one step");
    wait_att(1'b0, 8'h80);
    tick(2);
    chk({6'h0, mut_l, mut_r}, 8'h02, "left muted only");
    u_sdmc_host_model.wr(8'h14, 8'h00);
    wait_att(1'b0, 8'hF0);
    u_sdmc_host_model.wr(8'h16, 8'h80);
    tick(2);
    chk({7'h0, cfg.attenuation_range_select}, 8'h01, "wide range");
    u_sdmc_host_model.wr(8'h14, 8'h02);
    wait_att(1'b1, 8'h9A);
    tick(2);
    chk({7'h0, mut_r}, 8'h01, "right muted");
    $display("attenuator test done");
    end_sim;
  end
endmodule
`default_nettype wire
